// >>> rtl/slb_slice.sv
// What this block does
// R1: four-bit empty count per receive segment
// R2: empty count meaningful only on valid end
// R3: valid with error forces low bits zero
// R4: separate empty output for segments zero-three
// R5: ready high permits data, low stops it
// R6: ready follows fixed fifo fill threshold
// R7: overflow raised when data sent without ready
// R8: user honours ready so no overflow occurs
// R9: capture each valid segment data word; a beat that arrives while the fifo holds FILL_MAX entries is dropped
// R10: capture eleven-bit channel on each valid
// R11: channel range limited by range select input
// R12: receive outputs valid only with valid high
// R13: transmit inputs sampled only when valid high
// R14: user marks first transfer with start
// R15: error sampled only on valid end
// R16: empty n means n trailing lanes unused
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module slb_slice
    import slb_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // receive qualifiers and raw empty count from the neighbouring slice
    input wire logic [SEGS-1:0] rx_seg_valid,
    input wire logic [SEGS-1:0] rx_seg_packet_end,
    input wire logic [SEGS-1:0] rx_seg_packet_error,
    input wire logic [SEGS-1:0][EMPTY_W-1:0] rx_seg_empty_raw,
    // receive outputs, one cycle after the inputs
    output logic [SEGS-1:0] rx_seg_valid_out,
    output logic [EMPTY_W-1:0] rx_seg_empty_count0,
    output logic [EMPTY_W-1:0] rx_seg_empty_count1,
    output logic [EMPTY_W-1:0] rx_seg_empty_count2,
    output logic [EMPTY_W-1:0] rx_seg_empty_count3,
    // transmit user side
    input wire logic [SEGS-1:0] tx_seg_valid,
    input wire logic [SEGS-1:0] tx_seg_packet_start,
    input wire logic [SEGS-1:0] tx_seg_packet_end,
    input wire logic [SEGS-1:0] tx_seg_packet_error,
    input wire logic [SEGS-1:0][WORD_W-1:0] tx_seg_word,
    input wire logic [SEGS-1:0][CHAN_W-1:0] tx_seg_channel_number,
    input wire logic [RANGE_W-1:0] tx_channel_range_select,
    output logic tx_accept_ready,
    output logic tx_backpressure_violation,
    // transmit drain side toward the protocol engine
    output logic tx_out_valid,
    input wire logic tx_out_ready,
    output logic [SEGS-1:0] tx_out_seg_valid,
    output logic [SEGS-1:0] tx_out_seg_start,
    output logic [SEGS-1:0] tx_out_seg_end,
    output logic [SEGS-1:0] tx_out_seg_error,
    output logic [SEGS-1:0][WORD_W-1:0] tx_out_seg_word,
    output logic [SEGS-1:0][CHAN_W-1:0] tx_out_seg_channel,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // interrupt
    output logic irq
);

    logic [SEGS-1:0][EMPTY_W-1:0] empty_q;
    logic [SEGS-1:0] rx_valid_q;
    logic [PTR_W-1:0] wptr_q;
    logic [PTR_W-1:0] rptr_q;
    logic [CNT_W-1:0] fill_q;
    logic wr_en;
    logic rd_en;
    logic ovf_q;
    logic [CHAN_W-1:0] chan_mask;
    logic [SEGS-1:0] range_bad;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] status_q;
    logic [EV_W-1:0] mask_q;
    logic [DATA_W-1:0] rdata_q;
    logic status_rd;

    // empty count per segment; zero outside valid end so stale data never leaks
    genvar s;
    generate
        for (s = 0; s < SEGS; s++) begin : g_rx
            logic [EMPTY_W-1:0] empty_d;
            always_comb begin
                // raw count already counts unused trailing lanes [R16]
                empty_d = (rx_seg_valid[s] && rx_seg_packet_end[s]) ?
                          rx_seg_empty_raw[s] : '0; // [R1] [R2]
                if (rx_seg_valid[s] && rx_seg_packet_error[s]) begin
                    empty_d[EMPTY_FORCE_W-1:0] = '0; // [R3]
                end
            end
            always_ff @(posedge mclk) begin
                if (reset) begin
                    empty_q[s] <= '0;
                end else begin
                    empty_q[s] <= empty_d;
                end
            end

            empty_idle_a: assert property (@(posedge mclk) disable iff (reset) // [R2]
                !(rx_seg_valid[s] && rx_seg_packet_end[s]) |=> empty_q[s] == '0)
                else $error("empty count not zero outside valid end");
            empty_force_a: assert property (@(posedge mclk) disable iff (reset) // [R3]
                rx_seg_valid[s] && rx_seg_packet_error[s]
                |=> empty_q[s][EMPTY_FORCE_W-1:0] == '0)
                else $error("empty low bits not forced on error");
            empty_pass_a: assert property (@(posedge mclk) disable iff (reset) // [R1]
                rx_seg_valid[s] && rx_seg_packet_end[s] && !rx_seg_packet_error[s]
                |=> empty_q[s] == $past(rx_seg_empty_raw[s]))
                else $error("empty count not passed through");
            empty_top_a: assert property (@(posedge mclk) disable iff (reset) // [R3]
                rx_seg_valid[s] && rx_seg_packet_end[s] && rx_seg_packet_error[s]
                |=> empty_q[s][EMPTY_W-1] == $past(rx_seg_empty_raw[s][EMPTY_W-1]))
                else $error("empty top bit not kept on error");
        end
    endgenerate

    // valid travels with the count so both stay aligned
    always_ff @(posedge mclk) begin
        if (reset) begin
            rx_valid_q <= '0;
        end else begin
            rx_valid_q <= rx_seg_valid; // [R12]
        end
    end

    assign rx_seg_valid_out = rx_valid_q;
    assign rx_seg_empty_count0 = empty_q[0]; // [R4]
    assign rx_seg_empty_count1 = empty_q[1];
    assign rx_seg_empty_count2 = empty_q[2];
    assign rx_seg_empty_count3 = empty_q[3];

    // ready from fill; slack above the limit covers a user reacting late
    assign tx_accept_ready = fill_q < READY_LIMIT; // [R5] [R6]
    assign wr_en = (|tx_seg_valid) && (fill_q != FILL_MAX); // [R13]
    assign tx_out_valid = fill_q != '0;
    assign rd_en = tx_out_valid && tx_out_ready;

    // channel limit: bits above the selected range are dropped
    assign chan_mask = CHAN_W'((1 << (CHAN_BASE_LOG2 + int'(tx_channel_range_select))) - 1);

    // beat storage, one bank per segment, written at the write pointer and read at the read pointer
    generate
        for (s = 0; s < SEGS; s++) begin : g_tx
            logic [WORD_W-1:0] word_mem [FIFO_DEPTH];
            logic [CHAN_W-1:0] chan_mem [FIFO_DEPTH];
            logic [FIFO_DEPTH-1:0] val_mem;
            logic [FIFO_DEPTH-1:0] sop_mem;
            logic [FIFO_DEPTH-1:0] eop_mem;
            logic [FIFO_DEPTH-1:0] err_mem;
            assign range_bad[s] = tx_seg_valid[s] &&
                                  ((tx_seg_channel_number[s] & ~chan_mask) != '0); // [R11]
            always_ff @(posedge mclk) begin
                if (wr_en) begin
                    word_mem[wptr_q] <= tx_seg_word[s]; // [R9]
                    chan_mem[wptr_q] <= tx_seg_channel_number[s] & chan_mask; // [R10] [R11]
                end
            end
            // qualifiers reset so an unwritten slot never looks valid
            always_ff @(posedge mclk) begin
                if (reset) begin
                    val_mem <= '0;
                    sop_mem <= '0;
                    eop_mem <= '0;
                    err_mem <= '0;
                end else if (wr_en) begin
                    val_mem[wptr_q] <= tx_seg_valid[s]; // [R13]
                    sop_mem[wptr_q] <= tx_seg_valid[s] && tx_seg_packet_start[s];
                    eop_mem[wptr_q] <= tx_seg_valid[s] && tx_seg_packet_end[s];
                    err_mem[wptr_q] <= tx_seg_valid[s] && tx_seg_packet_end[s] &&
                                       tx_seg_packet_error[s]; // [R15]
                end
            end
            assign tx_out_seg_word[s] = word_mem[rptr_q];
            assign tx_out_seg_channel[s] = chan_mem[rptr_q];
            assign tx_out_seg_valid[s] = val_mem[rptr_q];
            assign tx_out_seg_start[s] = sop_mem[rptr_q];
            assign tx_out_seg_end[s] = eop_mem[rptr_q];
            assign tx_out_seg_error[s] = err_mem[rptr_q];
        end
    endgenerate

    // pointers and fill count
    always_ff @(posedge mclk) begin
        if (reset) begin
            wptr_q <= '0;
            rptr_q <= '0;
            fill_q <= '0;
        end else begin
            if (wr_en) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (rd_en) begin
                rptr_q <= rptr_q + 1'b1;
            end
            if (wr_en && !rd_en) begin
                fill_q <= fill_q + 1'b1;
            end else if (rd_en && !wr_en) begin
                fill_q <= fill_q - 1'b1;
            end
        end
    end

    // violation pulse: any valid beat while ready is low
    always_ff @(posedge mclk) begin
        if (reset) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= (|tx_seg_valid) && !tx_accept_ready; // [R7] [R8]
        end
    end
    assign tx_backpressure_violation = ovf_q;

    // events into sticky status; a read clears, a same-cycle event survives
    assign ev[EV_OVF] = (|tx_seg_valid) && !tx_accept_ready;
    assign ev[EV_RANGE] = wr_en && (|range_bad);
    assign ev[EV_RXERR] = |(rx_seg_valid & rx_seg_packet_end & rx_seg_packet_error);
    assign status_rd = reg_rd && (reg_addr == REG_STATUS);

    always_ff @(posedge mclk) begin
        if (reset) begin
            status_q <= '0;
        end else begin
            status_q <= (status_rd ? '0 : status_q) | ev;
        end
    end

    // mask register steers the interrupt
    always_ff @(posedge mclk) begin
        if (reset) begin
            mask_q <= MASK_RESET;
        end else if (reg_wr && (reg_addr == REG_MASK)) begin
            mask_q <= reg_wdata[EV_W-1:0];
        end
    end

    // read data one cycle after the strobe, zero otherwise and when unmapped
    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_STATUS: rdata_q <= DATA_W'(status_q);
                REG_MASK: rdata_q <= DATA_W'(mask_q);
                REG_FILL: rdata_q <= DATA_W'(fill_q);
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end
    assign reg_rdata = rdata_q;
    assign irq = |(status_q & mask_q);

    // transmit side checks
    ready_drop_a: assert property (@(posedge mclk) disable iff (reset) // [R6]
        fill_q >= READY_LIMIT |-> !tx_accept_ready)
        else $error("ready high above fill limit");
    ovf_raise_a: assert property (@(posedge mclk) disable iff (reset) // [R7]
        (|tx_seg_valid) && !tx_accept_ready |=> tx_backpressure_violation)
        else $error("violation not flagged");
    ovf_cause_a: assert property (@(posedge mclk) disable iff (reset) // [R7]
        tx_backpressure_violation |-> $past(!tx_accept_ready))
        else $error("violation without low ready");
    capture_word_a: assert property (@(posedge mclk) disable iff (reset) // [R9]
        wr_en && fill_q == '0 && tx_seg_valid[0]
        |=> tx_out_valid && tx_out_seg_valid[0]
            && tx_out_seg_word[0] == $past(tx_seg_word[0]))
        else $error("segment word not captured");
    idle_hold_a: assert property (@(posedge mclk) disable iff (reset) // [R13]
        !(|tx_seg_valid) |=> fill_q <= $past(fill_q))
        else $error("fifo grew without valid");
    err_qual_a: assert property (@(posedge mclk) disable iff (reset) // [R15]
        wr_en && fill_q == '0 && !tx_seg_packet_end[0] |=> !tx_out_seg_error[0])
        else $error("error captured without end");
    chan_range_a: assert property (@(posedge mclk) disable iff (reset) // [R11]
        tx_out_valid |-> (tx_out_seg_channel[1] & ~chan_mask) == '0 || $changed(chan_mask))
        else $error("channel beyond range");
    status_set_a: assert property (@(posedge mclk) disable iff (reset) // [R7]
        ev[EV_OVF] && mask_q[EV_OVF] |=> status_q[EV_OVF] ##0 irq)
        else $error("overflow event lost");
    ovf_quiet_a: assert property (@(posedge mclk) disable iff (reset) // [R7]
        !((|tx_seg_valid) && !tx_accept_ready) |=> !tx_backpressure_violation)
        else $error("violation without cause");
    ready_open_a: assert property (@(posedge mclk) disable iff (reset) // [R5]
        fill_q < READY_LIMIT |-> tx_accept_ready)
        else $error("ready low below fill limit");
    status_clear_a: assert property (@(posedge mclk) disable iff (reset) // [R7]
        status_rd && !(|ev) |=> status_q == '0)
        else $error("status not cleared by read");

    // receive valid must line up with the count it qualifies
    rx_align_a: assert property (@(posedge mclk) disable iff (reset) // [R12]
        1'b1 |=> rx_seg_valid_out == $past(rx_seg_valid))
        else $error("receive valid out of step");

    // main scenarios reached
    fill_full_c: cover property (@(posedge mclk) disable iff (reset) fill_q == FILL_MAX);
    range_seen_c: cover property (@(posedge mclk) disable iff (reset) ev[EV_RANGE]);
    ovf_seen_c: cover property (@(posedge mclk) disable iff (reset) tx_backpressure_violation);
    rx_force_c: cover property (@(posedge mclk) disable iff (reset)
        rx_seg_valid[0] && rx_seg_packet_end[0] && rx_seg_packet_error[0]);
    drain_c: cover property (@(posedge mclk) disable iff (reset)
        rd_en && wr_en ##1 rd_en);

endmodule
`default_nettype wire

// >>> rtl/slb_pkg.sv
package slb_pkg;
    // segment geometry
    localparam int SEGS = 4;
    localparam int WORD_W = 128;
    localparam int CHAN_W = 11;
    localparam int EMPTY_W = 4;
    localparam int EMPTY_FORCE_W = 3;
    // transmit fifo: ready drops at READY_LIMIT, slack to the top absorbs late beats
    localparam int FIFO_DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FILL_MAX = 5'h10;
    localparam logic [CNT_W-1:0] READY_LIMIT = 5'h0C;
    // channel range: 2**(CHAN_BASE_LOG2 + select) channels
    localparam int RANGE_W = 2;
    localparam int CHAN_BASE_LOG2 = 8;
    // register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] REG_FILL = 8'h08;
    // event bits, shared by status and mask
    localparam int EV_W = 3;
    localparam int EV_OVF = 0;
    localparam int EV_RANGE = 1;
    localparam int EV_RXERR = 2;
    localparam logic [EV_W-1:0] MASK_RESET = 3'h0;
endpackage

// >>> tb/slb_drain_model.sv
`timescale 1ns/1ps
`default_nettype none
module slb_drain_model (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // drain handshake
    input wire logic stall,
    output logic tx_out_ready
);
    // random acceptance mixes prompt and slow draining
    always_ff @(posedge mclk) begin
        if (reset || stall) begin
            tx_out_ready <= 1'b0;
        end else begin
            tx_out_ready <= 1'($urandom_range(0, 1));
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import slb_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [SEGS-1:0] rv = '0, re = '0, rerr = '0, tv = '0, ts = '0, te = '0, terr = '0;
    logic [SEGS-1:0] rvo, osv, oss, ose, oserr;
    logic [SEGS-1:0][EMPTY_W-1:0] raw = '0;
    logic [EMPTY_W-1:0] c0, c1, c2, c3;
    logic [SEGS-1:0][WORD_W-1:0] tw = '0, ow;
    logic [SEGS-1:0][CHAN_W-1:0] tc = '0, oc;
    logic [RANGE_W-1:0] sel = '0;
    logic [SEGS-1:0] busy = '0;
    logic rdy, viol, ov, ordy, irq, stall = 1'b1, rwr = 1'b0, rrd = 1'b0;
    logic rx_go = 1'b0, rx_go_d = 1'b0, rd_go_d = 1'b0;
    logic [ADDR_W-1:0] ra = '0;
    logic [DATA_W-1:0] rwd = '0, rdat, stat = '0;
    logic [19:0] rx_q[$];
    logic [DATA_W-1:0] rd_q[$];
    logic [15:0] tf_q[$];
    logic [SEGS-1:0][WORD_W-1:0] tw_q[$];
    logic [SEGS-1:0][CHAN_W-1:0] tc_q[$];
    int errors = 0, compares = 0, vcnt = 0, v0;
    slb_slice u_slb_slice (.mclk(mclk), .reset(reset), .rx_seg_valid(rv),
        .rx_seg_packet_end(re), .rx_seg_packet_error(rerr), .rx_seg_empty_raw(raw),
        .rx_seg_valid_out(rvo), .rx_seg_empty_count0(c0), .rx_seg_empty_count1(c1),
        .rx_seg_empty_count2(c2), .rx_seg_empty_count3(c3), .tx_seg_valid(tv),
        .tx_seg_packet_start(ts), .tx_seg_packet_end(te), .tx_seg_packet_error(terr),
        .tx_seg_word(tw), .tx_seg_channel_number(tc), .tx_channel_range_select(sel),
        .tx_accept_ready(rdy), .tx_backpressure_violation(viol), .tx_out_valid(ov),
        .tx_out_ready(ordy), .tx_out_seg_valid(osv), .tx_out_seg_start(oss),
        .tx_out_seg_end(ose), .tx_out_seg_error(oserr), .tx_out_seg_word(ow),
        .tx_out_seg_channel(oc), .reg_addr(ra), .reg_wdata(rwd), .reg_wr(rwr),
        .reg_rd(rrd), .reg_rdata(rdat), .irq(irq));
    slb_drain_model u_slb_drain_model (.mclk(mclk), .reset(reset), .stall(stall),
        .tx_out_ready(ordy));
    // free-running clock, 4 ns
    initial forever #2 mclk = ~mclk;
    task automatic note(input bit ok, input string what);
        compares++;
        if (!ok) begin
            errors++;
            $display("unexpected at %0t ns: %s", $time, what);
        end
    endtask
    task automatic cmp_rx(input logic [19:0] got, input logic [19:0] exp);
        note(got === exp, "receive empty count");
    endtask
    task automatic cmp_reg(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        note(got === exp, "register read data");
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        note(got === exp, "status flag");
    endtask
    task automatic cmp_beat(input logic [SEGS-1:0][WORD_W-1:0] w,
        input logic [SEGS-1:0][CHAN_W-1:0] c, input logic [15:0] f);
        logic [15:0] ef;
        logic [SEGS-1:0][WORD_W-1:0] ew;
        logic [SEGS-1:0][CHAN_W-1:0] ec;
        ef = tf_q.pop_front();
        ew = tw_q.pop_front();
        ec = tc_q.pop_front();
        for (int s = 0; s < SEGS; s++) begin
            if (ef[12+s]) note(w[s] === ew[s] && c[s] === ec[s], "transmit word");
        end
        note(f === ef, "transmit qualifiers");
    endtask
    // one strobe cycle, then a quiet cycle so strobes never collide
    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        ra <= a;
        rwd <= d;
        rwr <= 1'b1;
        @(posedge mclk);
        rwr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic reg_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
        ra <= a;
        rrd <= 1'b1;
        rd_q.push_back(x);
        @(posedge mclk);
        rrd <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rx_beat();
        logic [SEGS-1:0] v, e, r;
        logic [SEGS-1:0][EMPTY_W-1:0] n, x;
        v = 4'($urandom);
        e = 4'($urandom);
        r = 4'($urandom);
        n = 16'($urandom);
        for (int s = 0; s < SEGS; s++) begin
            x[s] = (v[s] & e[s]) ? n[s] : 4'h0;
            if (v[s] & r[s]) x[s][2:0] = 3'h0;
        end
        if (|(v & e & r)) stat[EV_RXERR] = 1'b1;
        rx_q.push_back({v, x});
        rv <= v;
        re <= e;
        rerr <= r;
        raw <= n;
        rx_go <= 1'b1;
        @(posedge mclk);
    endtask
    // polite beats look at ready with no beat in flight
    task automatic tx_beat(input bit ign, input bit keep);
        logic [SEGS-1:0] v, s, e, r;
        logic [SEGS-1:0][WORD_W-1:0] w;
        logic [SEGS-1:0][CHAN_W-1:0] c, m;
        if (!ign) begin
            @(negedge mclk);
            while (rdy !== 1'b1) @(negedge mclk);
            @(posedge mclk);
        end
        v = 4'($urandom_range(1, 15));
        e = 4'($urandom);
        s = v & ~busy;
        busy = (busy | v) & ~(v & e);
        r = 4'($urandom);
        for (int i = 0; i < SEGS; i++) begin
            w[i] = {$urandom, $urandom, $urandom, $urandom};
            c[i] = keep ? 11'($urandom) : 11'h000;
            m[i] = c[i] & 11'((1 << (CHAN_BASE_LOG2 + sel)) - 1);
            if (v[i] && m[i] !== c[i]) stat[EV_RANGE] = 1'b1;
        end
        if (keep) begin
            tf_q.push_back({v, s & v, e & v, r & e & v});
            tw_q.push_back(w);
            tc_q.push_back(m);
        end
        tv <= v;
        ts <= s;
        te <= e;
        terr <= r;
        tw <= w;
        tc <= c;
        @(posedge mclk);
    endtask
    always @(posedge mclk) begin
        rx_go_d <= rx_go;
        rd_go_d <= rrd;
        if (viol === 1'b1) vcnt <= vcnt + 1;
        if (ov === 1'b1 && ordy === 1'b1) begin
            if (tf_q.size() == 0) note(1'b0, "beat without request");
            else cmp_beat(ow, oc, {osv, oss, ose, oserr});
        end
    end
    always @(negedge mclk) begin
        if (rx_go_d) cmp_rx({rvo, c3, c2, c1, c0}, rx_q.pop_front());
        if (rd_go_d) cmp_reg(rdat, rd_q.pop_front());
    end
    task automatic results();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        $display("unexpected at %0t ns: watchdog expired", $time);
        results();
    end
    initial begin
        void'($urandom(32'h64d5));
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        reg_read(REG_MASK, 32'h0);
        reg_read(8'hFC, 32'h0);
        reg_write(REG_FILL, 32'hFF);
        reg_read(REG_FILL, 32'h0);
        $display("test registers done");
        repeat (40) rx_beat();
        rx_go <= 1'b0;
        rv <= '0;
        reg_write(REG_MASK, 32'h4);
        @(negedge mclk);
        cmp_flag(irq, stat[EV_RXERR]);
        @(posedge mclk);
        reg_read(REG_STATUS, stat);
        stat = '0;
        $display("test receive done");
        sel <= 2'($urandom);
        stall <= 1'b0;
        @(posedge mclk);
        repeat (30) begin
            tx_beat(1'b0, 1'b1);
            tv <= '0;
        end
        for (int i = 0; i < 300 && tf_q.size() != 0; i++) @(posedge mclk);
        cmp_flag(tf_q.size() == 0, 1'b1);
        cmp_flag(vcnt == 0, 1'b1);
        $display("test transmit done");
        v0 = vcnt;
        stall <= 1'b1;
        @(posedge mclk);
        // back-to-back beats past ready and past a full fifo
        for (int i = 0; i < 18; i++) tx_beat(1'b1, i < FIFO_DEPTH);
        tv <= '0;
        stat[EV_OVF] = 1'b1;
        reg_read(REG_FILL, 32'(FILL_MAX));
        cmp_flag(vcnt - v0 == 6, 1'b1);
        cmp_flag(rdy, 1'b0);
        reg_write(REG_MASK, 32'h1);
        @(negedge mclk);
        cmp_flag(irq, 1'b1);
        @(posedge mclk);
        reg_read(REG_STATUS, stat);
        stat = '0;
        @(negedge mclk);
        cmp_flag(irq, 1'b0);
        @(posedge mclk);
        stall <= 1'b0;
        for (int i = 0; i < 300 && tf_q.size() != 0; i++) @(posedge mclk);
        cmp_flag(tf_q.size() == 0, 1'b1);
        $display("test overflow done");
        results();
    end
endmodule
`default_nettype wire
